// ===== core/fbt_base_timer.sv
// 16-bit free-running base timer with apb registers
// Contract
// - with match reset, counter clears when it equals compare register zero.
// - with external reset, counter clears while either reset pin is low.
// - every reset of the counter loads zero.
// - overflow flag sets when selected bit 9, 14 or 15 overflows.
// - reading the value register while running returns the counter.
// - value read while held in reset is unspecified.
// - writing value while running loads it; counting continues from it.
// - value writes while held in reset are ignored.
// - counting starts when the run bit is set to one.
// - up/down mode counts up to FFFF then down toward zero.
// - up/down with match reset turns down two counts after a match.
// - up/down mode turns upward again when counting down reaches zero.
// - two-phase mode counts edges from one of two selectable pin pairs.
// - two-phase mode steps on every edge, up or down by phase order; the code does so only at ratio 31, else once per 2(n+1) edges.
// - clearing the run bit stops the timer and holds it in reset.
// - count source is clock or phase edges divided by 2(n+1); 31 undivided.
// - a two-bit field selects which reset condition clears the counter.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "fbt_cfg.svh"
`default_nettype none
module fbt_base_timer (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic phase_a_pin,
  input wire logic phase_b_pin,
  input wire logic phase_a_alt_pin,
  input wire logic phase_b_alt_pin,
  input wire logic ext_reset_pin_a_n,
  input wire logic ext_reset_pin_b_n,
  // to the rest of the unit
  output logic [15:0] timer_value,
  output logic compare_zero_match,
  output logic overflow_irq_flag
);
  import fbt_pkg::*;

  function automatic logic ones_up_to(input logic [15:0] v, input int top);
    logic r;
    r = 1'b1;
    for (int i = 0; i < 16; i++)
      if (i <= top)
        r = r & v[i];
    return r;
  endfunction

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic [4:0] divide_ratio_field;
  fbt_irq_bit_type irq_bit_sel;
  logic timer_run_bit;
  fbt_rst_src_type reset_select;
  fbt_mode_type count_mode;
  logic ovf_reset_bit9;
  logic phase_pin_select;
  logic [15:0] compare_zero_value;
  logic [15:0] count;
  fbt_dir_state_type dir_state;
  logic [5:0] div_cnt;
  logic [1:0] ext_sync1;
  logic [1:0] ext_sync2;
  logic [1:0] ext_sync3;
  logic [1:0] ext_level;

  wire hit_ctrl_a = paddr == `FBT_ADDR_CTRL_A;
  wire hit_ctrl_b = paddr == `FBT_ADDR_CTRL_B;
  wire hit_value = paddr == `FBT_ADDR_VALUE;
  wire hit_cmp = paddr == `FBT_ADDR_CMP0;
  wire hit_irq = paddr == `FBT_ADDR_IRQ;
  wire hit_any = hit_ctrl_a | hit_ctrl_b | hit_value | hit_cmp | hit_irq;
  wire apb_write = psel & penable & pwrite & hit_any;
  wire apb_setup_read = psel & ~penable & ~pwrite;
  wire wr_ctrl_a = apb_write & hit_ctrl_a;
  wire wr_ctrl_b = apb_write & hit_ctrl_b;
  wire wr_value = apb_write & hit_value;
  wire wr_cmp = apb_write & hit_cmp;
  wire wr_irq = apb_write & hit_irq;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  wire [31:0] rd_ctrl_a = {22'h000000, irq_bit_sel, 3'h0, divide_ratio_field};
  wire [31:0] rd_ctrl_b = {23'h000000, phase_pin_select, 1'b0, ovf_reset_bit9, count_mode, 1'b0,
                           reset_select, timer_run_bit};
  // counter reads zero while held in reset; software must not rely on it
  wire [31:0] rd_value = {16'h0000, count};
  wire [31:0] rd_cmp = {16'h0000, compare_zero_value};
  wire [31:0] rd_irq = {31'h00000000, overflow_irq_flag};
  wire [31:0] rd_mux = hit_ctrl_a ? rd_ctrl_a :
                       hit_ctrl_b ? rd_ctrl_b :
                       hit_value ? rd_value :
                       hit_cmp ? rd_cmp :
                       hit_irq ? rd_irq : `FBT_RDATA_ZERO;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      divide_ratio_field <= `FBT_DIV_RESET;
      irq_bit_sel <= FBT_IRQ_BIT9;
      timer_run_bit <= 1'b0;
      reset_select <= FBT_RST_NONE;
      count_mode <= FBT_MODE_INC;
      ovf_reset_bit9 <= 1'b0;
      phase_pin_select <= 1'b0;
      compare_zero_value <= `FBT_CMP_RESET;
      prdata <= `FBT_RDATA_ZERO;
    end
    else
    begin
      if (wr_ctrl_a)
      begin
        divide_ratio_field <= pwdata[`FBT_DIV_MSB:`FBT_DIV_LSB];
        irq_bit_sel <= fbt_irq_bit_type'(pwdata[`FBT_IRQSEL_MSB:`FBT_IRQSEL_LSB]);
      end
      if (wr_ctrl_b)
      begin
        timer_run_bit <= pwdata[`FBT_RUN_BIT];
        reset_select <= fbt_rst_src_type'(pwdata[`FBT_RSTSEL_MSB:`FBT_RSTSEL_LSB]);
        count_mode <= fbt_mode_type'(pwdata[`FBT_MODE_MSB:`FBT_MODE_LSB]);
        ovf_reset_bit9 <= pwdata[`FBT_OVF9_BIT];
        phase_pin_select <= pwdata[`FBT_PINSEL_BIT];
      end
      if (wr_cmp)
        compare_zero_value <= pwdata[15:0];
      if (apb_setup_read)
        prdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // external reset pins, three-stage synchronisers
  // ----------------------------------------
  wire [1:0] ext_agree = ~(ext_sync2 ^ ext_sync3);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_sync1 <= 2'h3;
      ext_sync2 <= 2'h3;
      ext_sync3 <= 2'h3;
      ext_level <= 2'h3;
    end
    else
    begin
      ext_sync1 <= {ext_reset_pin_b_n, ext_reset_pin_a_n};
      ext_sync2 <= ext_sync1;
      ext_sync3 <= ext_sync2;
      ext_level <= (ext_agree & ext_sync3) | (~ext_agree & ext_level);
    end
  end

  // ----------------------------------------
  // count source and divider
  // ----------------------------------------
  logic quad_step;
  logic quad_up;

  fbt_quad_decoder u_quad (
    .pclk(pclk),
    .presetn(presetn),
    .phase_a_pin(phase_a_pin),
    .phase_b_pin(phase_b_pin),
    .phase_a_alt_pin(phase_a_alt_pin),
    .phase_b_alt_pin(phase_b_alt_pin),
    .phase_pin_select(phase_pin_select),
    .step(quad_step),
    .step_up(quad_up)
  );

  wire is_quad = count_mode == FBT_MODE_QUAD;
  wire src_event = is_quad ? quad_step : 1'b1;
  wire div_bypass = divide_ratio_field == `FBT_DIV_NONE;
  wire [5:0] div_limit = {divide_ratio_field, 1'b1};
  // at or past the limit, so a smaller ratio written mid-run takes effect at once
  wire div_last = div_cnt >= div_limit;
  // timer_count_source enable: one pulse per 2(n+1) source events below 31, one per event at 31
  wire timer_count_source = timer_run_bit & src_event & (div_bypass | div_last);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt <= 6'h00;
    else if (!timer_run_bit || (src_event && div_last))
      div_cnt <= 6'h00;
    else if (src_event)
      div_cnt <= div_cnt + 6'h01;
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  wire is_updown = count_mode == FBT_MODE_UPDOWN;
  wire at_max = count == `FBT_COUNT_MAX;
  wire at_zero = count == `FBT_COUNT_ZERO;
  wire cmp_match = count == compare_zero_value;
  wire updown_turn_down = is_updown & ((dir_state == FBT_DIR_UP & at_max) | dir_state == FBT_DIR_SKID2);
  wire updown_turn_up = is_updown & dir_state == FBT_DIR_DOWN & at_zero;
  wire go_up = is_quad ? quad_up :
               is_updown ? ((dir_state != FBT_DIR_DOWN & ~updown_turn_down) | updown_turn_up) : 1'b1;
  wire ovf9 = go_up & ones_up_to(count, 9);
  wire ovf14 = go_up & ones_up_to(count, 14);
  wire ovf15 = go_up & at_max;
  wire ext_low = ~&ext_level;
  wire run_clear = ~timer_run_bit;
  wire ext_clear = reset_select == FBT_RST_EXT & ext_low;
  wire match_clear = reset_select == FBT_RST_MATCH & ~is_updown & cmp_match;
  wire ovf_clear = reset_select == FBT_RST_OVF & (ovf_reset_bit9 ? ovf9 : ovf15);
  wire irq_event = timer_count_source & (irq_bit_sel == FBT_IRQ_BIT9 ? ovf9 :
                                         irq_bit_sel == FBT_IRQ_BIT14 ? ovf14 :
                                         irq_bit_sel == FBT_IRQ_BIT15 ? ovf15 : 1'b0);
  wire [15:0] stepped = go_up ? count + 16'h0001 : count - 16'h0001;

  logic [15:0] next_count;
  always_comb
  begin
    if (run_clear || ext_clear)
      next_count = `FBT_COUNT_ZERO;
    else if (wr_value)
      next_count = pwdata[15:0];
    else if (timer_count_source && (match_clear || ovf_clear))
      next_count = `FBT_COUNT_ZERO;
    else if (timer_count_source)
      next_count = stepped;
    else
      next_count = count;
  end

  // up/down direction, with two extra up counts after a compare match
  fbt_dir_state_type next_dir_state;
  always_comb
  begin
    next_dir_state = dir_state;
    if (!is_updown || run_clear)
      next_dir_state = FBT_DIR_UP;
    else if (timer_count_source)
    begin
      case (dir_state)
        FBT_DIR_UP:
          if (at_max)
            next_dir_state = FBT_DIR_DOWN;
          else if (reset_select == FBT_RST_MATCH && cmp_match)
            next_dir_state = FBT_DIR_SKID1;
        FBT_DIR_SKID1:
          next_dir_state = FBT_DIR_SKID2;
        FBT_DIR_SKID2:
          next_dir_state = FBT_DIR_DOWN;
        FBT_DIR_DOWN:
          if (at_zero)
            next_dir_state = FBT_DIR_UP;
        default:
          next_dir_state = FBT_DIR_UP;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= `FBT_COUNT_ZERO;
      dir_state <= FBT_DIR_UP;
      overflow_irq_flag <= 1'b0;
    end
    else
    begin
      count <= next_count;
      dir_state <= next_dir_state;
      // a new overflow wins over a clear in the same cycle
      overflow_irq_flag <= irq_event | (overflow_irq_flag & ~(wr_irq & pwdata[`FBT_IRQ_FLAG_BIT]));
    end
  end

  assign timer_value = count;
  assign compare_zero_match = timer_run_bit & cmp_match;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  stop_holds_zero_a: assert property (!timer_run_bit |=> count == 16'h0000)
    else $error("counter not held at zero while stopped");
  match_clear_a: assert property (timer_count_source && match_clear && !ext_clear && !wr_value
                                  |=> count == 16'h0000)
    else $error("counter not cleared on compare match");
  ext_clear_a: assert property (timer_run_bit && reset_select == FBT_RST_EXT && ext_low
                                |=> count == 16'h0000)
    else $error("counter not cleared by external reset pin");
  ovf_clear_a: assert property (timer_count_source && reset_select == FBT_RST_OVF && ovf_reset_bit9
                                && !ext_clear && !wr_value && count[9:0] == 10'h3FF && go_up
                                |=> count == 16'h0000)
    else $error("counter not cleared on bit 9 overflow");
  irq_set_a: assert property (timer_count_source && irq_bit_sel == FBT_IRQ_BIT14 && go_up
                              && count[14:0] == 15'h7FFF |=> overflow_irq_flag)
    else $error("overflow flag not set on bit 14 overflow");
  write_load_a: assert property (timer_run_bit && wr_value && !ext_clear
                                 |=> count == $past(pwdata[15:0]))
    else $error("value write not loaded while running");
  write_ignored_a: assert property (!timer_run_bit && wr_value |=> count == 16'h0000)
    else $error("value write took effect while in reset");
  up_wrap_a: assert property (timer_count_source && count_mode == FBT_MODE_INC && reset_select == FBT_RST_NONE
                              && !wr_value && at_max |=> count == 16'h0000)
    else $error("counter did not wrap to zero");
  down_turn_a: assert property (is_updown && timer_run_bit && dir_state == FBT_DIR_DOWN && at_zero
                                && timer_count_source && !ext_clear && !wr_value
                                |=> dir_state == FBT_DIR_UP && count == 16'h0001)
    else $error("up/down counter did not turn upward at zero");
  match_skid_a: assert property (is_updown && timer_run_bit && dir_state == FBT_DIR_SKID2 && timer_count_source
                                 |=> dir_state == FBT_DIR_DOWN)
    else $error("up/down counter did not turn down after the match");
  read_value_a: assert property (apb_setup_read && hit_value |=> prdata[15:0] == $past(count))
    else $error("value read does not show the counter");
  quad_step_a: assert property (timer_count_source && is_quad && !ext_clear && !wr_value
                                && !match_clear && !ovf_clear
                                |=> count == $past(count) + ($past(quad_up) ? 16'h0001 : 16'hFFFF))
    else $error("two-phase edge did not step the counter");

  count_wrap_c: cover property (timer_count_source && at_max && count_mode == FBT_MODE_INC);
  updown_turn_c: cover property (dir_state == FBT_DIR_DOWN ##1 dir_state == FBT_DIR_UP);
  quad_down_c: cover property (timer_count_source && is_quad && !quad_up);
  irq_clear_c: cover property (overflow_irq_flag ##1 !overflow_irq_flag);
endmodule // fbt_base_timer
`default_nettype wire

// ===== core/fbt_cfg.svh
// register map, field positions and reset values of the base timer
`ifndef FBT_CFG_SVH
`define FBT_CFG_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define FBT_ADDR_CTRL_A 8'h00
`define FBT_ADDR_CTRL_B 8'h04
`define FBT_ADDR_VALUE 8'h08
`define FBT_ADDR_CMP0 8'h0C
`define FBT_ADDR_IRQ 8'h10
// ----------------------------------------
// timer_ctrl_a fields
// ----------------------------------------
`define FBT_DIV_LSB 0
`define FBT_DIV_MSB 4
`define FBT_IRQSEL_LSB 8
`define FBT_IRQSEL_MSB 9
// ----------------------------------------
// timer_ctrl_b fields
// ----------------------------------------
`define FBT_RUN_BIT 0
`define FBT_RSTSEL_LSB 1
`define FBT_RSTSEL_MSB 2
`define FBT_MODE_LSB 4
`define FBT_MODE_MSB 5
`define FBT_OVF9_BIT 6
`define FBT_PINSEL_BIT 8
// ----------------------------------------
// irq_request_reg fields
// ----------------------------------------
`define FBT_IRQ_FLAG_BIT 0
// ----------------------------------------
// values
// ----------------------------------------
`define FBT_DIV_NONE 5'h1F
`define FBT_DIV_RESET 5'h00
`define FBT_COUNT_MAX 16'hFFFF
`define FBT_COUNT_ZERO 16'h0000
`define FBT_CMP_RESET 16'h0000
`define FBT_RDATA_ZERO 32'h00000000
`endif

// ===== core/fbt_pkg.sv
// types of the base timer
package fbt_pkg;
  typedef enum logic [1:0] {FBT_MODE_INC = 2'b00, FBT_MODE_UPDOWN = 2'b01, FBT_MODE_QUAD = 2'b10} fbt_mode_type;
  typedef enum logic [1:0] {FBT_RST_NONE = 2'b00, FBT_RST_MATCH = 2'b01, FBT_RST_EXT = 2'b10,
                            FBT_RST_OVF = 2'b11} fbt_rst_src_type;
  typedef enum logic [1:0] {FBT_IRQ_BIT9 = 2'b00, FBT_IRQ_BIT14 = 2'b01, FBT_IRQ_BIT15 = 2'b10} fbt_irq_bit_type;
  typedef enum logic [1:0] {FBT_DIR_UP = 2'b00, FBT_DIR_SKID1 = 2'b01, FBT_DIR_SKID2 = 2'b11,
                            FBT_DIR_DOWN = 2'b10} fbt_dir_state_type;
endpackage

// ===== core/fbt_quad_decoder.sv
// pin synchroniser and two-phase edge decoder
`timescale 1ns/1ps
`default_nettype none
module fbt_quad_decoder (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // phase pins
  input wire logic phase_a_pin,
  input wire logic phase_b_pin,
  input wire logic phase_a_alt_pin,
  input wire logic phase_b_alt_pin,
  input wire logic phase_pin_select,
  // decoded events
  output logic step,
  output logic step_up
);
  import fbt_pkg::*;

  // ----------------------------------------
  // three-stage synchronisers, change taken when stages two and three agree
  // ----------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [3:0] level;
  logic prev_a;
  logic prev_b;
  wire [3:0] pins_raw = {phase_b_alt_pin, phase_a_alt_pin, phase_b_pin, phase_a_pin};
  wire [3:0] agree = ~(sync2 ^ sync3);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
      level <= 4'h0;
    end
    else
    begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      level <= (agree & sync3) | (~agree & level);
    end
  end

  // ----------------------------------------
  // pin pair selection and quadrature decode
  // ----------------------------------------
  wire cur_a = phase_pin_select ? level[2] : level[0];
  wire cur_b = phase_pin_select ? level[3] : level[1];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
    end
    else
    begin
      prev_a <= cur_a;
      prev_b <= cur_b;
    end
  end

  // exactly one phase moved: a valid edge of either input
  assign step = (cur_a ^ prev_a) ^ (cur_b ^ prev_b);
  // phase a leading phase b counts up
  assign step_up = cur_a ^ prev_b;
endmodule // fbt_quad_decoder
`default_nettype wire

// ===== tb/fbt_encoder_model.sv
// far side model: two-phase encoder on both pin pairs and the external reset pins
`timescale 1ns/1ps
`default_nettype none
module fbt_encoder_model (
  // clock
  input wire logic pclk,
  // commands from the bench
  input wire logic step_req,
  input wire logic step_up,
  input wire logic step_pair,
  input wire logic rst_a_low,
  input wire logic rst_b_low,
  // pins
  output logic phase_a_pin,
  output logic phase_b_pin,
  output logic phase_a_alt_pin,
  output logic phase_b_alt_pin,
  output logic ext_reset_pin_a_n,
  output logic ext_reset_pin_b_n
);
  logic [1:0] pos_main = 2'h0;
  logic [1:0] pos_alt = 2'h0;
  // ----------------------------------------
  // one phase changes per step; a rising position means phase a leads
  // ----------------------------------------
  always @(posedge pclk)
  begin
    if (step_req && !step_pair)
      pos_main <= step_up ? pos_main + 2'h1 : pos_main - 2'h1;
    if (step_req && step_pair)
      pos_alt <= step_up ? pos_alt + 2'h1 : pos_alt - 2'h1;
  end
  assign phase_a_pin = pos_main[1] ^ pos_main[0];
  assign phase_b_pin = pos_main[1];
  assign phase_a_alt_pin = pos_alt[1] ^ pos_alt[0];
  assign phase_b_alt_pin = pos_alt[1];
  assign ext_reset_pin_a_n = !rst_a_low;
  assign ext_reset_pin_b_n = !rst_b_low;
endmodule // fbt_encoder_model
`default_nettype wire

// ===== tb/fbt_base_timer_bench.sv
// self-checking bench of the base timer with a cycle model of the counter
`timescale 1ns/1ps
`include "fbt_cfg.svh"
`default_nettype none
module fbt_base_timer_bench;
  import fbt_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pa, pb, paa, pba, rna, rnb;
  logic e_req = 1'b0;
  logic e_up = 1'b0;
  logic e_pair = 1'b0;
  logic rst_a_low = 1'b0;
  logic rst_b_low = 1'b0;
  logic [15:0] timer_value;
  logic [15:0] t0;
  logic compare_zero_match;
  logic overflow_irq_flag;
  logic [31:0] rdat;
  logic rerr;
  logic covf9 = 1'b0;
  fbt_mode_type cmode = FBT_MODE_INC;
  fbt_rst_src_type crst = FBT_RST_NONE;
  int n_errors = 0;
  int samples_checked = 0;
  int mv, mdir, skid, ccmp, v;
  int bits[4] = '{9, 14, 15, 15};
  logic [7:0] addrs[5] = '{`FBT_ADDR_CTRL_A, `FBT_ADDR_CTRL_B, `FBT_ADDR_VALUE, `FBT_ADDR_CMP0, `FBT_ADDR_IRQ};

  always #20 pclk = ~pclk;

  fbt_base_timer fbt_base_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_a_pin(pa), .phase_b_pin(pb), .phase_a_alt_pin(paa), .phase_b_alt_pin(pba),
    .ext_reset_pin_a_n(rna), .ext_reset_pin_b_n(rnb), .timer_value(timer_value),
    .compare_zero_match(compare_zero_match), .overflow_irq_flag(overflow_irq_flag));
  fbt_encoder_model fbt_encoder_model_inst (.pclk(pclk), .step_req(e_req), .step_up(e_up), .step_pair(e_pair),
    .rst_a_low(rst_a_low), .rst_b_low(rst_b_low), .phase_a_pin(pa), .phase_b_pin(pb), .phase_a_alt_pin(paa),
    .phase_b_alt_pin(pba), .ext_reset_pin_a_n(rna), .ext_reset_pin_b_n(rnb));

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic finish_test();
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait for pready
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
    apb(1'b1, addr, wd);
  endtask

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input logic err);
    apb(1'b0, addr, 32'h0);
    chk("prdata", exp, rdat);
    chk("pslverr", {31'h0, err}, {31'h0, rerr});
  endtask

  task automatic cfg(input logic run, input fbt_rst_src_type rs, input fbt_mode_type md, input logic o9,
                     input logic pin);
    wr(`FBT_ADDR_CTRL_B, {23'h0, pin, 1'b0, o9, md, 1'b0, rs, run});
    crst = rs;
    cmode = md;
    covf9 = o9;
    mv = 0;
    mdir = 0;
    skid = 0;
  endtask

  task automatic enc(input logic pair, input logic up, input int n);
    repeat (n)
    begin
      e_req <= 1'b1;
      e_pair <= pair;
      e_up <= up;
      @(posedge pclk);
      e_req <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  endtask

  // ----------------------------------------
  // counter model: one count per clock
  // ----------------------------------------
  task automatic mstep();
    int m;
    m = (1 << (covf9 ? 10 : 16)) - 1;
    if (cmode == FBT_MODE_UPDOWN && mdir == 1)
    begin
      skid = 0;
      mdir = (mv == 0) ? 0 : 1;
      mv = (mv == 0) ? 1 : mv - 1;
    end
    else if (cmode == FBT_MODE_UPDOWN)
    begin
      if (skid == 2 || mv == 16'hFFFF)
        mdir = 1;
      skid = (skid > 0) ? skid + 1 : ((crst == FBT_RST_MATCH && mv == ccmp) ? 1 : 0);
      mv = (mdir == 1) ? mv - 1 : mv + 1;
    end
    else if ((crst == FBT_RST_MATCH && mv == ccmp) || (crst == FBT_RST_OVF && (mv & m) == m))
      mv = 0;
    else
      mv = (mv + 1) & 16'hFFFF;
  endtask

  task automatic run_model(input int n);
    for (int i = 0; i <= n; i++)
    begin
      if (i > 0)
      begin
        @(posedge pclk);
        mstep();
      end
      #1;
      chk("timer_value", mv, {16'h0, timer_value});
      chk("compare_match", {31'h0, mv == ccmp}, {31'h0, compare_zero_match});
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'hab8f10f2));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (addrs[i])
      rd(addrs[i], 32'h0, 1'b0);
    rd(8'h14, 32'h0, 1'b1);
    wr(`FBT_ADDR_VALUE, 32'h1234);
    rd(`FBT_ADDR_VALUE, 32'h0, 1'b0);
    for (int s = 0; s < 4; s++)
    begin
      cfg(1'b0, FBT_RST_NONE, FBT_MODE_INC, 1'b0, 1'b0);
      @(posedge pclk);
      #1 chk("stopped", 32'h0, {16'h0, timer_value});
      wr(`FBT_ADDR_CTRL_A, 32'h1F | (s << 8));
      wr(`FBT_ADDR_IRQ, 32'h1);
      cfg(1'b1, FBT_RST_NONE, FBT_MODE_INC, 1'b0, 1'b0);
      mv = (1 << (bits[s] + 1)) - 2;
      wr(`FBT_ADDR_VALUE, mv);
      run_model(4);
      chk("irq_flag", {31'h0, s != 3}, {31'h0, overflow_irq_flag});
      rd(`FBT_ADDR_IRQ, s != 3, 1'b0);
      wr(`FBT_ADDR_IRQ, 32'h1);
      rd(`FBT_ADDR_IRQ, 32'h0, 1'b0);
    end
    for (int n = 0; n < 4; n++)
    begin
      wr(`FBT_ADDR_CTRL_A, 32'h300 | n);
      repeat (2) @(posedge pclk);
      #1 t0 = timer_value;
      repeat (10 * (n + 1)) @(posedge pclk);
      #1 chk("divided", {16'h0, t0 + 16'h5}, {16'h0, timer_value});
    end
    wr(`FBT_ADDR_CTRL_A, 32'h31F);
    for (int o = 0; o < 2; o++)
    begin
      cfg(1'b1, FBT_RST_OVF, FBT_MODE_INC, o, 1'b0);
      mv = o ? 32'h3FD : 32'hFFFD;
      wr(`FBT_ADDR_VALUE, mv);
      run_model(5);
    end
    cfg(1'b0, FBT_RST_NONE, FBT_MODE_INC, 1'b0, 1'b0);
    ccmp = 8;
    wr(`FBT_ADDR_CMP0, ccmp);
    cfg(1'b1, FBT_RST_MATCH, FBT_MODE_INC, 1'b0, 1'b0);
    mv = 5;
    wr(`FBT_ADDR_VALUE, mv);
    run_model(12);
    cfg(1'b0, FBT_RST_NONE, FBT_MODE_INC, 1'b0, 1'b0);
    cfg(1'b1, FBT_RST_NONE, FBT_MODE_UPDOWN, 1'b0, 1'b0);
    mv = 16'hFFFC;
    wr(`FBT_ADDR_VALUE, mv);
    run_model(8);
    cfg(1'b0, FBT_RST_NONE, FBT_MODE_INC, 1'b0, 1'b0);
    ccmp = 4;
    wr(`FBT_ADDR_CMP0, ccmp);
    cfg(1'b1, FBT_RST_MATCH, FBT_MODE_UPDOWN, 1'b0, 1'b0);
    mv = 2;
    wr(`FBT_ADDR_VALUE, mv);
    run_model(14);
    for (int p = 0; p < 2; p++)
    begin
      cfg(1'b0, FBT_RST_NONE, FBT_MODE_INC, 1'b0, 1'b0);
      cfg(1'b1, FBT_RST_EXT, FBT_MODE_INC, 1'b0, 1'b0);
      rst_a_low <= (p == 0);
      rst_b_low <= (p == 1);
      repeat (8) @(posedge pclk);
      #1 chk("ext_held", 32'h0, {16'h0, timer_value});
      @(posedge pclk);
      rst_a_low <= 1'b0;
      rst_b_low <= 1'b0;
      repeat (8) @(posedge pclk);
      #1 chk("ext_released", 32'h1, {31'h0, timer_value !== 16'h0});
    end
    for (int r = 0; r < 3; r++)
    begin
      cfg(1'b0, FBT_RST_NONE, FBT_MODE_INC, 1'b0, 1'b0);
      wr(`FBT_ADDR_CTRL_A, r == 2 ? 32'h300 : 32'h31F);
      cfg(1'b1, FBT_RST_NONE, FBT_MODE_QUAD, 1'b0, r == 1);
      v = $urandom & 32'hFFFF;
      wr(`FBT_ADDR_VALUE, v);
      rd(`FBT_ADDR_VALUE, v, 1'b0);
      enc(r == 1, 1'b1, 8);
      enc(r != 1, 1'b1, 4);
      enc(r == 1, 1'b0, 4);
      rd(`FBT_ADDR_VALUE, (v + (r == 2 ? 2 : 4)) & 32'hFFFF, 1'b0);
    end
    finish_test();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    finish_test();
  end
endmodule // fbt_base_timer_bench
`default_nettype wire
